// file: dv/decoder_model.sv
`timescale 1ns/100ps
module decoder_model (
    input wire logic mclk, // Core clock.
    output pcs_pkg::op_t op_code, // Operation for the block.
    output logic [10:0] op_literal, // Operand.
    output logic [7:0] w_value, // Working register.
    output logic [7:0] low_value, // Byte written to the low byte.
    output logic [2:0] flags_in, // Live flags.
    output logic [4:0] bank_in, // Live bank select.
    output logic [15:0] ptr0_in, // Live pointer 0.
    output logic [15:0] ptr1_in // Live pointer 1.
);
    initial begin
        op_code = pcs_pkg::op_none;
        {op_literal, w_value, low_value, flags_in, bank_in, ptr0_in, ptr1_in} = '0;
    end
    // Context changes with every operation so a stale shadow capture shows up.
    task automatic issue(input pcs_pkg::op_t op, input logic [10:0] lit, input logic [7:0] w);
        op_code <= op;
        op_literal <= lit;
        w_value <= w;
        low_value <= lit[7:0];
        {flags_in, bank_in, ptr0_in, ptr1_in} <= 40'($urandom) ^ {$urandom, 8'h0};
        @(posedge mclk);
        op_code <= pcs_pkg::op_none;
        @(posedge mclk);
    endtask
    // Two operations on consecutive edges, so the back-to-back paths are exercised too.
    task automatic pair(input pcs_pkg::op_t op_a, input pcs_pkg::op_t op_b,
        input logic [10:0] lit, input logic [7:0] w);
        op_code <= op_a;
        op_literal <= lit;
        w_value <= w;
        @(posedge mclk);
        op_code <= op_b;
        @(posedge mclk);
        op_code <= pcs_pkg::op_none;
        @(posedge mclk);
    endtask
endmodule

// file: dv/program_counter_and_stack_test.sv
`timescale 1ns/100ps
module program_counter_and_stack_test;
    logic mclk, rst_b, psel, penable, pwrite, pready, pslverr, sfre, ctx_restore;
    logic fault_reset, irq, rerr;
    logic [13:0] paddr;
    logic [31:0] pwdata, prdata, rdat;
    pcs_pkg::op_t op_code;
    logic [10:0] op_literal;
    logic [7:0] w_value, low_value, working_shadow, b;
    logic [2:0] flags_in, flags_shadow;
    logic [4:0] bank_in, bank_select_shadow;
    logic [15:0] ptr0_in, ptr1_in, ptr0_shadow, ptr1_shadow;
    logic [14:0] pc, e;
    logic [6:0] pc_latch, l;
    logic [14:0] stk[$];
    pcs_pkg::op_t ops[6] = '{pcs_pkg::op_call, pcs_pkg::op_branch_w, pcs_pkg::op_branch_rel,
        pcs_pkg::op_step, pcs_pkg::op_low_wr, pcs_pkg::op_call_w};
    int num_errors = 0;
    int checks = 0;
    int nf = 0;
    int nr = 0;
    decoder_model u_decoder_model (.mclk, .op_code, .op_literal, .w_value, .low_value,
        .flags_in, .bank_in, .ptr0_in, .ptr1_in);
    program_counter_and_stack u_program_counter_and_stack (.mclk, .rst_b, .psel, .penable,
        .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr, .op_code, .op_literal,
        .w_value, .low_value, .stack_fault_reset_enable(sfre), .flags_in, .bank_in,
        .ptr0_in, .ptr1_in, .pc, .pc_latch, .ctx_restore, .flags_shadow, .working_shadow,
        .bank_select_shadow, .ptr0_shadow, .ptr1_shadow, .fault_reset, .irq);
    initial begin
        mclk = 1'b0;
        forever #2.5 mclk = ~mclk;
    end
    // Pulses are counted mid-cycle, so a check at the next rising edge already sees them.
    always @(negedge mclk) begin
        nf <= nf + int'(fault_reset === 1'b1);
        nr <= nr + int'(ctx_restore === 1'b1);
    end
    task automatic print_verdict();
        if (num_errors == 0 && checks > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask
    task automatic chk(input string nm, input logic [31:0] x, input logic [31:0] g);
        checks++;
        if (g !== x) begin
            num_errors++;
            $display("[FAIL] %s expected %h seen %h", nm, x, g);
        end
    endtask
    // An idle cycle follows each access so psel is never raised at its own release edge.
    task automatic apb(input logic wr, input logic [11:0] idx, input logic [31:0] d);
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= {idx, 2'b00};
        pwdata <= d;
        @(posedge mclk);
        penable <= 1'b1;
        do begin
            @(posedge mclk);
        end while (pready !== 1'b1);
        rdat = prdata;
        rerr = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge mclk);
    endtask
    task automatic rd(input logic [11:0] idx, input logic [31:0] x, input string nm);
        apb(1'b0, idx, 32'h0);
        chk(nm, x, rdat);
    endtask
    task automatic top(input logic [14:0] x);
        rd(pcs_pkg::IDX_STACK_TOP_LOW, {24'h0, x[7:0]}, "stack_top_low");
        rd(pcs_pkg::IDX_STACK_TOP_HIGH, {25'h0, x[14:8]}, "stack_top_high");
    endtask
    function automatic logic [14:0] target(input pcs_pkg::op_t op, input logic [14:0] p,
        input logic [10:0] lit, input logic [7:0] w);
        case (op)
            pcs_pkg::op_call: return {l[6:3], lit};
            pcs_pkg::op_call_w: return {l, w};
            pcs_pkg::op_branch_w: return p + 15'h1 + {7'h0, w};
            pcs_pkg::op_branch_rel: return p + 15'h1 + {{6{lit[8]}}, lit[8:0]};
            pcs_pkg::op_step: return p + 15'h1;
            default: return {l, lit[7:0]};
        endcase
    endfunction
    initial begin
        logic [10:0] lit;
        logic [7:0] w;
        {rst_b, psel, penable, pwrite, paddr, pwdata, sfre} = '0;
        void'($urandom(32'h4fb76ad7));
        repeat (4) @(posedge mclk);
        rst_b <= 1'b1;
        @(posedge mclk);
        chk("pc", 32'h0, {17'h0, pc});
        rd(pcs_pkg::IDX_STACK_POINTER, 32'h1f, "stack_pointer");
        apb(1'b1, pcs_pkg::IDX_IRQ_MASK, 32'h3);
        for (int i = 0; i < 6; i++) begin
            l = 7'($urandom);
            b = 8'($urandom);
            apb(1'b1, pcs_pkg::IDX_PC_HIGH_LATCH, {25'h0, l});
            apb(1'b1, pcs_pkg::IDX_PC_LOW_BYTE, {24'h0, b});
            e = {l, b};
            chk("pc", {17'h0, e}, {17'h0, pc});
            rd(pcs_pkg::IDX_PC_LOW_BYTE, {24'h0, b}, "pc_low_byte");
            foreach (ops[k]) begin
                lit = 11'($urandom);
                w = 8'($urandom);
                if (ops[k] inside {pcs_pkg::op_call, pcs_pkg::op_call_w}) stk.push_back(e + 15'h1);
                e = target(ops[k], e, lit, w);
                u_decoder_model.issue(ops[k], lit, w);
                chk("pc", {17'h0, e}, {17'h0, pc});
            end
            rd(pcs_pkg::IDX_STACK_POINTER, 32'h1, "stack_pointer");
            top(stk[1]);
            while (stk.size() > 0) begin
                e = stk.pop_back();
                u_decoder_model.issue(stk.size() > 0 ? pcs_pkg::op_retlit : pcs_pkg::op_return,
                    11'h0, 8'h0);
                chk("pc", {17'h0, e}, {17'h0, pc});
            end
            rd(pcs_pkg::IDX_STACK_POINTER, 32'h1f, "stack_pointer");
            chk("pc_latch", {25'h0, l}, {25'h0, pc_latch});
            u_decoder_model.pair(pcs_pkg::op_call, pcs_pkg::op_return, 11'($urandom), 8'h0);
            chk("pc", {17'h0, e + 15'h1}, {17'h0, pc});
        end
        for (int i = 0; i < 17; i++) u_decoder_model.issue(pcs_pkg::op_call, 11'(i), 8'h0);
        rd(pcs_pkg::IDX_STACK_POINTER, 32'h0, "stack_pointer");
        top({l[6:3], 11'd15} + 15'h1);
        rd(pcs_pkg::IDX_POWER_CONTROL, 32'h80, "power_control");
        chk("irq", 32'h1, {31'h0, irq});
        apb(1'b1, pcs_pkg::IDX_IRQ_MASK, 32'h0);
        repeat (2) @(posedge mclk);
        chk("irq", 32'h0, {31'h0, irq});
        apb(1'b1, pcs_pkg::IDX_IRQ_STATUS, 32'h3);
        rd(pcs_pkg::IDX_IRQ_STATUS, 32'h0, "irq_status");
        apb(1'b1, pcs_pkg::IDX_IRQ_MASK, 32'h3);
        repeat (2) @(posedge mclk);
        chk("irq", 32'h0, {31'h0, irq});
        repeat (2) u_decoder_model.issue(pcs_pkg::op_return, 11'h0, 8'h0);
        rd(pcs_pkg::IDX_STACK_POINTER, 32'h0e, "stack_pointer");
        rd(pcs_pkg::IDX_POWER_CONTROL, 32'hc0, "power_control");
        apb(1'b1, pcs_pkg::IDX_STACK_POINTER, 32'h5);
        apb(1'b1, pcs_pkg::IDX_STACK_TOP_LOW, 32'h5a);
        apb(1'b1, pcs_pkg::IDX_STACK_TOP_HIGH, 32'h25);
        top(15'h255a);
        apb(1'b1, pcs_pkg::IDX_POWER_CONTROL, 32'h0);
        apb(1'b1, pcs_pkg::IDX_STACK_POINTER, 32'h1f);
        sfre <= 1'b1;
        u_decoder_model.issue(pcs_pkg::op_return, 11'h0, 8'h0);
        chk("fault_reset", 32'h1, nf);
        chk("pc", 32'h0, {17'h0, pc});
        chk("pc_latch", 32'h0, {25'h0, pc_latch});
        rd(pcs_pkg::IDX_POWER_CONTROL, 32'h40, "power_control");
        l = 7'($urandom);
        apb(1'b1, pcs_pkg::IDX_PC_HIGH_LATCH, {25'h0, l});
        apb(1'b1, pcs_pkg::IDX_PC_LOW_BYTE, 32'h33);
        e = {l, 8'h33};
        w = 8'($urandom);
        u_decoder_model.issue(pcs_pkg::op_intr, 11'h0, w);
        chk("pc", {17'h0, pcs_pkg::INT_VECTOR}, {17'h0, pc});
        top(e);
        chk("working_shadow", {24'h0, w}, {24'h0, working_shadow});
        chk("ptr_shadows", {ptr0_in, ptr1_in}, {ptr0_shadow, ptr1_shadow});
        chk("flags_bank_shadows", {24'h0, flags_in, bank_in},
            {24'h0, flags_shadow, bank_select_shadow});
        rd(pcs_pkg::IDX_PC_LATCH_SHADOW, {25'h0, l}, "pc_latch_shadow");
        u_decoder_model.issue(pcs_pkg::op_retint, 11'h0, 8'h0);
        chk("pc", {17'h0, e}, {17'h0, pc});
        chk("ctx_restore", 32'h1, nr);
        u_decoder_model.pair(pcs_pkg::op_intr, pcs_pkg::op_retint, 11'h0, 8'($urandom));
        chk("pc", {17'h0, e}, {17'h0, pc});
        chk("ctx_restore", 32'h2, nr);
        rd(12'hfec, 32'h0, "unmapped");
        chk("pslverr", 32'h1, {31'h0, rerr});
        print_verdict();
    end
    initial begin
        #100000;
        num_errors++;
        print_verdict();
    end
endmodule

// file: hdl/event_irq.sv
`timescale 1ns/100ps
module event_irq #(
    parameter int N = 2
) (
    input wire logic mclk, // Core clock.
    input wire logic rst_b, // Asynchronous reset, active low.
    input wire logic [N-1:0] ev, // One-cycle event pulses.
    input wire logic clr_wr, // Status write strobe.
    input wire logic [N-1:0] clr_bits, // Ones clear status bits.
    input wire logic mask_wr, // Mask write strobe.
    input wire logic [N-1:0] mask_bits, // New mask value.
    output logic [N-1:0] status, // Sticky status.
    output logic [N-1:0] mask, // Mask, one enables.
    output logic irq // Level interrupt.
);
    always_ff @(posedge mclk or negedge rst_b) begin
        if (!rst_b) begin
            status <= '0;
        end else begin
            // An event in the clearing cycle survives.
            status <= (status & ~(clr_wr ? clr_bits : '0)) | ev;
        end
    end

    always_ff @(posedge mclk or negedge rst_b) begin
        if (!rst_b) begin
            mask <= '0;
        end else if (mask_wr) begin
            mask <= mask_bits;
        end
    end

    always_ff @(posedge mclk or negedge rst_b) begin
        if (!rst_b) begin
            irq <= 1'b0;
        end else begin
            irq <= |(status & mask);
        end
    end
endmodule

// file: hdl/program_counter_and_stack.sv
// Local design decision: the APB interface to the registers.
`timescale 1ns/100ps
module program_counter_and_stack (
    input wire logic mclk, // Core clock, 200 MHz.
    input wire logic rst_b, // Asynchronous reset, active low.
    input wire logic psel, // APB select.
    input wire logic penable, // APB access phase.
    input wire logic pwrite, // APB direction, high for write.
    input wire logic [13:0] paddr, // APB byte address.
    input wire logic [31:0] pwdata, // APB write data.
    output logic [31:0] prdata, // APB read data.
    output logic pready, // APB ready.
    output logic pslverr, // APB error on unmapped address.
    input wire pcs_pkg::op_t op_code, // Operation from the decoder this cycle.
    input wire logic [10:0] op_literal, // Instruction operand.
    input wire logic [7:0] w_value, // Working register.
    input wire logic [7:0] low_value, // Value an instruction writes to the low byte.
    input wire logic stack_fault_reset_enable, // Configuration bit, static.
    input wire logic [2:0] flags_in, // Live flags for context save.
    input wire logic [4:0] bank_in, // Live bank select for context save.
    input wire logic [15:0] ptr0_in, // Live indirect pointer 0.
    input wire logic [15:0] ptr1_in, // Live indirect pointer 1.
    output logic [14:0] pc, // Program counter.
    output logic [6:0] pc_latch, // High latch.
    output logic ctx_restore, // Pulse: restore outputs below into the core.
    output logic [2:0] flags_shadow, // Saved flags.
    output logic [7:0] working_shadow, // Saved working register.
    output logic [4:0] bank_select_shadow, // Saved bank select.
    output logic [15:0] ptr0_shadow, // Saved indirect pointer 0.
    output logic [15:0] ptr1_shadow, // Saved indirect pointer 1.
    output logic fault_reset, // Pulse: stack fault device reset.
    output logic irq // Level interrupt.
);
    logic [4:0] sp_q;
    logic [6:0] pc_sh_q;
    logic [1:0] ovf_unf_q;
    logic [14:0] top;
    logic [14:0] push_val;
    logic [14:0] st_wdata;
    logic [3:0] st_widx;
    logic st_we;
    logic push;
    logic pop;
    logic ovf;
    logic unf;
    logic fault;
    logic [4:0] sp_push;
    logic [4:0] sp_pop;
    logic access;
    logic wr;
    logic [11:0] idx;
    logic hit;
    logic [31:0] rd_word;
    logic [1:0] irq_status;
    logic [1:0] irq_mask;

    function automatic logic [14:0] pc_plus(input logic [14:0] base, input logic [14:0] off);
        return base + 15'h0001 + off;
    endfunction

    assign push = (op_code == pcs_pkg::op_call) || (op_code == pcs_pkg::op_call_w)
        || (op_code == pcs_pkg::op_intr);
    assign pop = (op_code == pcs_pkg::op_return) || (op_code == pcs_pkg::op_retlit)
        || (op_code == pcs_pkg::op_retint);
    assign ovf = push && (sp_q == pcs_pkg::SP_LAST);
    assign unf = pop && (sp_q == pcs_pkg::SP_EMPTY);
    assign fault = stack_fault_reset_enable && (ovf || unf);
    // Wrapped overflow lands on entry zero, wrapped underflow reads entry fifteen.
    assign sp_push = ovf ? pcs_pkg::SP_FIRST : 5'(sp_q + 5'h01);
    assign sp_pop = unf ? pcs_pkg::SP_UNF_WRAP : 5'(sp_q - 5'h01);
    // Interrupts return to the instruction that was not executed.
    assign push_val = (op_code == pcs_pkg::op_intr) ? pc : pc_plus(pc, 15'h0000);

    assign access = psel && penable;
    assign idx = paddr[13:2];
    assign wr = access && pready && pwrite && hit;

    always_comb begin
        st_we = 1'b0;
        st_widx = sp_q[3:0];
        st_wdata = top;
        if (push && !fault) begin
            st_we = 1'b1;
            st_widx = sp_push[3:0];
            st_wdata = push_val;
        end else if (!push && !pop && wr && idx == pcs_pkg::IDX_STACK_TOP_LOW) begin
            st_we = 1'b1;
            st_wdata = {top[14:8], pwdata[7:0]};
        end else if (!push && !pop && wr && idx == pcs_pkg::IDX_STACK_TOP_HIGH) begin
            st_we = 1'b1;
            st_wdata = {pwdata[6:0], top[7:0]};
        end
    end

    return_stack #(.DEPTH(16), .WIDTH(pcs_pkg::PC_W), .IDX_W(4)) u_stack (
        .mclk(mclk),
        .wr_en(st_we),
        .wr_idx(st_widx),
        .wr_data(st_wdata),
        .rd_idx(sp_q[3:0]),
        .rd_data(top)
    );

    event_irq #(.N(2)) u_irq (
        .mclk(mclk),
        .rst_b(rst_b),
        .ev({ovf, unf}),
        .clr_wr(wr && idx == pcs_pkg::IDX_IRQ_STATUS),
        .clr_bits(pwdata[1:0]),
        .mask_wr(wr && idx == pcs_pkg::IDX_IRQ_MASK),
        .mask_bits(pwdata[1:0]),
        .status(irq_status),
        .mask(irq_mask),
        .irq(irq)
    );

    always_ff @(posedge mclk or negedge rst_b) begin
        if (!rst_b) begin
            pc <= pcs_pkg::PC_RESET;
        end else if (fault) begin
            pc <= pcs_pkg::PC_RESET;
        end else begin
            unique case (op_code)
                pcs_pkg::op_none: begin
                    if (wr && idx == pcs_pkg::IDX_PC_LOW_BYTE) begin
                        pc <= {pc_latch, pwdata[7:0]};
                    end
                end
                pcs_pkg::op_step: pc <= pc_plus(pc, 15'h0000);
                pcs_pkg::op_call: pc <= {pc_latch[6:3], op_literal};
                pcs_pkg::op_call_w: pc <= {pc_latch, w_value};
                pcs_pkg::op_branch_w: pc <= pc_plus(pc, {7'h00, w_value});
                pcs_pkg::op_branch_rel: begin
                    pc <= pc_plus(pc, {{(pcs_pkg::PC_W - pcs_pkg::REL_W){op_literal[8]}},
                        op_literal[8:0]});
                end
                pcs_pkg::op_return, pcs_pkg::op_retlit, pcs_pkg::op_retint: pc <= top;
                pcs_pkg::op_intr: pc <= pcs_pkg::INT_VECTOR;
                pcs_pkg::op_low_wr: pc <= {pc_latch, low_value};
                default: pc <= pc;
            endcase
        end
    end

    always_ff @(posedge mclk or negedge rst_b) begin
        if (!rst_b) begin
            sp_q <= pcs_pkg::SP_EMPTY;
        end else if (fault) begin
            sp_q <= pcs_pkg::SP_EMPTY;
        end else if (push) begin
            sp_q <= sp_push;
        end else if (pop) begin
            sp_q <= sp_pop;
        end else if (wr && idx == pcs_pkg::IDX_STACK_POINTER) begin
            sp_q <= pwdata[4:0];
        end
    end

    // The latch only moves on software writes, reset, a stack fault or context restore.
    always_ff @(posedge mclk or negedge rst_b) begin
        if (!rst_b) begin
            pc_latch <= 7'h00;
        end else if (fault) begin
            pc_latch <= 7'h00;
        end else if (op_code == pcs_pkg::op_retint) begin
            pc_latch <= pc_sh_q;
        end else if (wr && idx == pcs_pkg::IDX_PC_HIGH_LATCH) begin
            pc_latch <= pwdata[6:0];
        end
    end

    always_ff @(posedge mclk or negedge rst_b) begin
        if (!rst_b) begin
            flags_shadow <= 3'h0;
            working_shadow <= 8'h00;
            bank_select_shadow <= 5'h00;
            pc_sh_q <= 7'h00;
            ptr0_shadow <= 16'h0000;
            ptr1_shadow <= 16'h0000;
        end else if (op_code == pcs_pkg::op_intr && !fault) begin
            flags_shadow <= flags_in;
            working_shadow <= w_value;
            bank_select_shadow <= bank_in;
            pc_sh_q <= pc_latch;
            ptr0_shadow <= ptr0_in;
            ptr1_shadow <= ptr1_in;
        end else if (wr) begin
            unique case (idx)
                pcs_pkg::IDX_FLAGS_SHADOW: flags_shadow <= pwdata[2:0];
                pcs_pkg::IDX_WORKING_SHADOW: working_shadow <= pwdata[7:0];
                pcs_pkg::IDX_BANK_SELECT_SHADOW: bank_select_shadow <= pwdata[4:0];
                pcs_pkg::IDX_PC_LATCH_SHADOW: pc_sh_q <= pwdata[6:0];
                pcs_pkg::IDX_POINTER0_LOW_SHADOW: ptr0_shadow[7:0] <= pwdata[7:0];
                pcs_pkg::IDX_POINTER0_HIGH_SHADOW: ptr0_shadow[15:8] <= pwdata[7:0];
                pcs_pkg::IDX_POINTER1_LOW_SHADOW: ptr1_shadow[7:0] <= pwdata[7:0];
                pcs_pkg::IDX_POINTER1_HIGH_SHADOW: ptr1_shadow[15:8] <= pwdata[7:0];
                default: flags_shadow <= flags_shadow;
            endcase
        end
    end

    always_ff @(posedge mclk or negedge rst_b) begin
        if (!rst_b) begin
            ctx_restore <= 1'b0;
            fault_reset <= 1'b0;
        end else begin
            ctx_restore <= (op_code == pcs_pkg::op_retint) && !fault;
            fault_reset <= fault;
        end
    end

    // Software writes may clear or set the flags, but a new event always wins.
    always_ff @(posedge mclk or negedge rst_b) begin
        if (!rst_b) begin
            ovf_unf_q <= 2'b00;
        end else if (wr && idx == pcs_pkg::IDX_POWER_CONTROL) begin
            ovf_unf_q <= {pwdata[pcs_pkg::OVF_BIT] | ovf, pwdata[pcs_pkg::UNF_BIT] | unf};
        end else begin
            ovf_unf_q <= ovf_unf_q | {ovf, unf};
        end
    end

    always_comb begin
        rd_word = 32'h0000_0000;
        hit = (paddr[1:0] == 2'b00);
        unique case (idx)
            pcs_pkg::IDX_FLAGS_SHADOW: rd_word[2:0] = flags_shadow;
            pcs_pkg::IDX_WORKING_SHADOW: rd_word[7:0] = working_shadow;
            pcs_pkg::IDX_BANK_SELECT_SHADOW: rd_word[4:0] = bank_select_shadow;
            pcs_pkg::IDX_PC_LATCH_SHADOW: rd_word[6:0] = pc_sh_q;
            pcs_pkg::IDX_POINTER0_LOW_SHADOW: rd_word[7:0] = ptr0_shadow[7:0];
            pcs_pkg::IDX_POINTER0_HIGH_SHADOW: rd_word[7:0] = ptr0_shadow[15:8];
            pcs_pkg::IDX_POINTER1_LOW_SHADOW: rd_word[7:0] = ptr1_shadow[7:0];
            pcs_pkg::IDX_POINTER1_HIGH_SHADOW: rd_word[7:0] = ptr1_shadow[15:8];
            pcs_pkg::IDX_STACK_POINTER: rd_word[4:0] = sp_q;
            pcs_pkg::IDX_STACK_TOP_LOW: rd_word[7:0] = top[7:0];
            pcs_pkg::IDX_STACK_TOP_HIGH: rd_word[6:0] = top[14:8];
            pcs_pkg::IDX_PC_LOW_BYTE: rd_word[7:0] = pc[7:0];
            pcs_pkg::IDX_PC_HIGH_LATCH: rd_word[6:0] = pc_latch;
            pcs_pkg::IDX_POWER_CONTROL: begin
                rd_word[pcs_pkg::OVF_BIT] = ovf_unf_q[1];
                rd_word[pcs_pkg::UNF_BIT] = ovf_unf_q[0];
            end
            pcs_pkg::IDX_IRQ_STATUS: rd_word[1:0] = irq_status;
            pcs_pkg::IDX_IRQ_MASK: rd_word[1:0] = irq_mask;
            default: hit = 1'b0;
        endcase
    end

    // One wait state: ready rises in the second access cycle, data is sampled there.
    always_ff @(posedge mclk or negedge rst_b) begin
        if (!rst_b) begin
            pready <= 1'b0;
            pslverr <= 1'b0;
            prdata <= 32'h0000_0000;
        end else begin
            pready <= access && !pready;
            pslverr <= access && !pready && !hit;
            if (access && !pready) begin
                prdata <= (hit && !pwrite) ? rd_word : 32'h0000_0000;
            end
        end
    end

    AST_FAULT_CLEARS_PC: assert property (@(posedge mclk) disable iff (!rst_b)
        fault |=> (pc == 15'h0000) && fault_reset && (sp_q == 5'h1f))
        else $error("stack fault did not reset counter and pointer");
    AST_LOW_BYTE_WRITE: assert property (@(posedge mclk) disable iff (!rst_b)
        (op_code == pcs_pkg::op_low_wr) |=> pc == {$past(pc_latch), $past(low_value)})
        else $error("low byte write did not load latch and byte");
    AST_CALL_TARGET: assert property (@(posedge mclk) disable iff (!rst_b)
        (op_code == pcs_pkg::op_call) && !fault
        |=> (pc[10:0] == $past(op_literal)) && (pc[14:11] == $past(pc_latch[6:3])))
        else $error("direct call target wrong");
    AST_CALL_W_TARGET: assert property (@(posedge mclk) disable iff (!rst_b)
        (op_code == pcs_pkg::op_call_w) && !fault |=> pc == {$past(pc_latch), $past(w_value)})
        else $error("computed call target wrong");
    AST_BRANCH_W_TARGET: assert property (@(posedge mclk) disable iff (!rst_b)
        (op_code == pcs_pkg::op_branch_w)
        |=> pc == 15'($past(pc) + 15'h0001 + {7'h00, $past(w_value)}))
        else $error("branch by W target wrong");
    AST_PUSH_THEN_POP: assert property (@(posedge mclk) disable iff (!rst_b)
        (op_code == pcs_pkg::op_call) && !ovf ##1 (op_code == pcs_pkg::op_return)
        |=> (pc == 15'($past(pc, 2) + 15'h0001)) && (sp_q == $past(sp_q, 2)))
        else $error("return did not restore address and pointer");
    AST_WRAP: assert property (@(posedge mclk) disable iff (!rst_b)
        ovf && !stack_fault_reset_enable |=> (sp_q == 5'h00) && !fault_reset)
        else $error("overflow did not wrap to entry zero");
    AST_FLAGS: assert property (@(posedge mclk) disable iff (!rst_b)
        (ovf |=> ovf_unf_q[1] && irq_status[1]) and (unf |=> ovf_unf_q[0] && irq_status[0]))
        else $error("stack flag not set");
    AST_LATCH_STABLE: assert property (@(posedge mclk) disable iff (!rst_b)
        (push || (pop && op_code != pcs_pkg::op_retint)) && !fault && !wr |=> $stable(pc_latch))
        else $error("push or pop changed the latch");
    AST_SHADOW_SAVE: assert property (@(posedge mclk) disable iff (!rst_b)
        (op_code == pcs_pkg::op_intr) && !fault ##1 (op_code == pcs_pkg::op_retint)
        |=> ctx_restore && (working_shadow == $past(w_value, 2)) && (pc_latch == $past(pc_latch, 2)))
        else $error("context not saved and restored");
endmodule

// file: hdl/return_stack.sv
`timescale 1ns/100ps
module return_stack #(
    parameter int DEPTH = 16,
    parameter int WIDTH = 15,
    parameter int IDX_W = 4
) (
    input wire logic mclk, // Core clock.
    input wire logic wr_en, // Write strobe.
    input wire logic [IDX_W-1:0] wr_idx, // Entry written.
    input wire logic [WIDTH-1:0] wr_data, // Data written.
    input wire logic [IDX_W-1:0] rd_idx, // Entry read.
    output logic [WIDTH-1:0] rd_data // Entry contents, combinational.
);
    // Entries are not reset; software must not rely on stale contents.
    logic [WIDTH-1:0] mem [DEPTH];

    always_ff @(posedge mclk) begin
        if (wr_en) begin
            mem[wr_idx] <= wr_data;
        end
    end

    assign rd_data = mem[rd_idx];
endmodule

// file: inc/pcs_pkg.sv
package pcs_pkg;

    // Printed register offsets are register indices; byte address is index * 4.
    localparam logic [11:0] IDX_FLAGS_SHADOW = 12'hfe4;
    localparam logic [11:0] IDX_WORKING_SHADOW = 12'hfe5;
    localparam logic [11:0] IDX_BANK_SELECT_SHADOW = 12'hfe6;
    localparam logic [11:0] IDX_PC_LATCH_SHADOW = 12'hfe7;
    localparam logic [11:0] IDX_POINTER0_LOW_SHADOW = 12'hfe8;
    localparam logic [11:0] IDX_POINTER0_HIGH_SHADOW = 12'hfe9;
    localparam logic [11:0] IDX_POINTER1_LOW_SHADOW = 12'hfea;
    localparam logic [11:0] IDX_POINTER1_HIGH_SHADOW = 12'hfeb;
    localparam logic [11:0] IDX_STACK_POINTER = 12'hfed;
    localparam logic [11:0] IDX_STACK_TOP_LOW = 12'hfee;
    localparam logic [11:0] IDX_STACK_TOP_HIGH = 12'hfef;
    localparam logic [11:0] IDX_PC_LOW_BYTE = 12'hf00;
    localparam logic [11:0] IDX_PC_HIGH_LATCH = 12'hf01;
    localparam logic [11:0] IDX_POWER_CONTROL = 12'hf02;
    localparam logic [11:0] IDX_IRQ_STATUS = 12'hf03;
    localparam logic [11:0] IDX_IRQ_MASK = 12'hf04;

    // Field positions in power_control_reg and in the interrupt registers.
    localparam int OVF_BIT = 7;
    localparam int UNF_BIT = 6;
    localparam int EV_OVF = 1;
    localparam int EV_UNF = 0;

    localparam int PC_W = 15;
    localparam int SP_W = 5;
    localparam int REL_W = 9;
    localparam logic [4:0] SP_EMPTY = 5'h1f;
    localparam logic [4:0] SP_LAST = 5'h0f;
    localparam logic [4:0] SP_FIRST = 5'h00;
    localparam logic [4:0] SP_UNF_WRAP = 5'h0e;
    localparam logic [14:0] PC_RESET = 15'h0000;
    localparam logic [14:0] INT_VECTOR = 15'h0004;

    typedef enum logic [3:0] {
        op_none = 4'h0,
        op_step = 4'h1,
        op_call = 4'h2,
        op_call_w = 4'h3,
        op_branch_w = 4'h4,
        op_branch_rel = 4'h5,
        op_return = 4'h6,
        op_retlit = 4'h7,
        op_retint = 4'h8,
        op_intr = 4'h9,
        op_low_wr = 4'ha
    } op_t;

endpackage
